// File: tb/cpu_partner.sv
// ==========================================================
// Core side: stack and program memory holding the vector
module cpu_partner #(
  parameter logic [15:0] VEC = 16'h2a51
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        slow,
  input  wire logic        push_valid,
  input  wire logic [7:0]  push_data,
  input  wire logic        pop_req,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  output logic             pop_valid,
  output logic      [7:0]  pop_data,
  output logic             mem_rvalid,
  output logic      [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] stk[$];
  int         dly;
  // Idle data toggles each cycle so a stale byte never matches
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stk.delete();
      dly = 0;
      mem_rvalid <= 1'b0;
      pop_valid  <= 1'b0;
      mem_rdata  <= 8'h00;
      pop_data   <= 8'h00;
    end else begin
      if (push_valid)
        stk.push_back(push_data);
      mem_rvalid <= 1'b0;
      pop_valid  <= 1'b0;
      mem_rdata  <= ~mem_rdata;
      pop_data   <= ~pop_data;
      if ((mem_rd || pop_req) && !mem_rvalid && !pop_valid) begin
        if (dly < (slow ? 3 : 0))
          dly++;
        else if (mem_rd) begin
          dly = 0;
          mem_rvalid <= 1'b1;
          mem_rdata  <= (mem_addr == 16'h0000) ? VEC[15:8] : VEC[7:0];
        end else begin
          dly = 0;
          pop_valid <= 1'b1;
          pop_data  <= stk.pop_back();
        end
      end
    end
  end
endmodule // cpu_partner

// File: tb/irq_ctrl_sva.sv
// ==========================================================
// Port-level checks of the interrupt controller
module irq_ctrl_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        instr_end,
  input wire logic        interrupt_return_instr_exec,
  input wire logic        int_cycle,
  input wire logic        irq_req,
  input wire logic        push_valid,
  input wire logic        mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rvalid,
  input wire logic        branch_valid,
  input wire logic        restore_valid,
  input wire logic        pop_req
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // An acknowledge is taken only from idle; a return wins
  wire logic take_w = instr_end && irq_req && !int_cycle && !interrupt_return_instr_exec;
  wire logic lo_w = mem_rd && mem_rvalid && mem_addr == 16'h0000;
  wire logic hi_w = mem_rd && mem_rvalid && mem_addr == 16'h0001;

  ack_start_a: assert property (take_w |=> int_cycle)
    else $error("acknowledge did not start");
  ack_cause_a: assert property (
    $rose(int_cycle) |-> $past(instr_end) || $past(interrupt_return_instr_exec))
    else $error("machine cycle without a boundary");
  push_seq_a: assert property (take_w |=> !push_valid
    ##1 push_valid [*3] ##1 (mem_rd && mem_addr == 16'h0000))
    else $error("push sequence wrong");
  ge_clear_a: assert property (push_valid |-> !irq_req)
    else $error("request live during service");
  vec_lo_a: assert property (lo_w |=> mem_rd && mem_addr == 16'h0001)
    else $error("second vector fetch missing");
  branch_a: assert property (
    hi_w |=> branch_valid ##1 (!branch_valid && !int_cycle))
    else $error("branch not one cycle");
  ret_pop_a: assert property (
    interrupt_return_instr_exec && !int_cycle |=> pop_req && !push_valid)
    else $error("return did not pop");
  restore_a: assert property (restore_valid |=> !restore_valid)
    else $error("restore not a pulse");
  rd_wait_a: assert property (hsel && htrans[1] && hready && !hwrite
    |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");

  cover property (take_w);
  cover property (restore_valid);
  cover property (hi_w);
endmodule // irq_ctrl_sva

// File: tb/single_vector_interrupt_control_tb_top.sv
module single_vector_interrupt_control_tb_top;
  import irq_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] VEC = 16'h2a51;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        slow = 1'b0, ext_irq_line_a = 1'b1, ext_irq_line_b = 1'b1;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [5:0]  ev = '0;
  logic [15:0] pc_cur = 16'hbeef, mem_addr, branch_pc, restore_pc;
  logic [7:0]  flags_cur = 8'h5a, push_data, pop_data, mem_rdata;
  logic [7:0]  restore_flags, t0_ctrl, pwm_ctrl;
  logic [1:0]  page_sel;
  logic        hreadyout, hresp, push_valid, pop_req, pop_valid, mem_rd;
  logic        mem_rvalid, branch_valid, restore_valid, int_cycle;
  logic        irq_req, irq;
  int          bad_count = 0, checks = 0;
  wire logic [3:0] done_w = {restore_valid, branch_valid, 1'b0, hreadyout};

  // ==========================================================
  // Clock, design and core model
  always #12.5 hclk = ~hclk;
  single_vector_interrupt_control i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .pwm_ovf_evt(ev[0]), .t0_match_evt(ev[1]), .ext_irq_line_a,
    .ext_irq_line_b, .instr_end(ev[2]), .ei_exec(ev[4]),
    .di_exec(ev[5]), .interrupt_return_instr_exec(ev[3]), .pc_cur, .flags_cur,
    .push_valid, .push_data, .pop_req, .pop_valid, .pop_data, .mem_rd,
    .mem_addr, .mem_rvalid, .mem_rdata, .branch_valid, .branch_pc,
    .restore_valid, .restore_pc, .restore_flags, .int_cycle, .irq_req,
    .page_sel, .t0_ctrl, .pwm_ctrl, .irq);
  cpu_partner #(.VEC(VEC)) i_partner (
    .hclk, .hresetn, .slow, .push_valid, .push_data, .pop_req, .mem_rd,
    .mem_addr, .pop_valid, .pop_data, .mem_rvalid, .mem_rdata);

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Bounded wait; a hang ends the run with a mismatch
  task automatic wait_on(input int k);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (done_w[k] !== 1'b1 && n < 200);
    if (done_w[k] !== 1'b1) begin
      bad_count++;
      end_of_test();
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_on(0);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_on(0);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge hclk);
    ev[k] <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic sc_reset();
    rchk(SYSMODE_ADDR, 8'h00);
    rchk(T0CTL_ADDR, 8'h00);
    rchk(PWMCTL_ADDR, 8'h00);
    rchk(P0FLAGS_ADDR, 8'h00);
    rchk(12'h010, 8'h00);
    bus(1'b1, SYSMODE_ADDR, 8'hff);
    rchk(SYSMODE_ADDR, 8'h07);
    chk(page_sel, 32'h3);
    bus(1'b1, SYSMODE_ADDR, 8'h00);
    pulse(4);
    rchk(SYSMODE_ADDR, 8'h04);
    pulse(5);
    rchk(SYSMODE_ADDR, 8'h00);
  endtask
  task automatic sc_gate();
    bus(1'b1, T0CTL_ADDR, 8'h02);
    pulse(1);
    rchk(T0CTL_ADDR, 8'h03);
    chk(t0_ctrl, 32'h03);
    chk(irq_req, 32'h0);
    bus(1'b1, T0CTL_ADDR, 8'h03);
    bus(1'b1, SYSMODE_ADDR, 8'h04);
    rchk(T0CTL_ADDR, 8'h03);
    chk(irq_req, 32'h1);
    bus(1'b1, T0CTL_ADDR, 8'h02);
    pulse(0);
    rchk(T0CTL_ADDR, 8'h02);
    chk(irq_req, 32'h0);
    bus(1'b1, PWMCTL_ADDR, 8'h03);
    @(posedge hclk);
    chk(irq_req, 32'h1);
    chk(pwm_ctrl, 32'h03);
  endtask
  // Pending is left set by hardware, so the handler clears it
  task automatic sc_ack(input logic s);
    slow <= s;
    pulse(0);
    pulse(2);
    wait_on(2);
    chk(branch_pc, VEC);
    chk({i_partner.stk[0], i_partner.stk[1], i_partner.stk[2]},
        {pc_cur[7:0], pc_cur[15:8], flags_cur});
    rchk(SYSMODE_ADDR, 8'h00);
    rchk(PWMCTL_ADDR, 8'h03);
    rchk(T0CTL_ADDR, 8'h02);
    bus(1'b1, PWMCTL_ADDR, 8'h02);
    pulse(3);
    wait_on(3);
    chk({restore_pc, restore_flags}, {pc_cur, flags_cur});
    rchk(SYSMODE_ADDR, 8'h04);
  endtask
  task automatic sc_ext();
    bus(1'b1, P0FLAGS_ADDR, 8'h0a);
    ext_irq_line_a <= 1'b0;
    repeat (4) @(posedge hclk);
    rchk(P0FLAGS_ADDR, 8'h0b);
    ext_irq_line_b <= 1'b0;
    repeat (4) @(posedge hclk);
    rchk(P0FLAGS_ADDR, 8'h0f);
    chk(irq_req, 32'h1);
    ext_irq_line_a <= 1'b1;
    ext_irq_line_b <= 1'b1;
    bus(1'b1, P0FLAGS_ADDR, 8'h0a);
    repeat (4) @(posedge hclk);
    rchk(P0FLAGS_ADDR, 8'h0a);
  endtask
  task automatic sc_evt();
    rchk(EVSTAT_ADDR, 8'h3f);
    bus(1'b1, EVSTAT_ADDR, 8'h3f);
    rchk(EVSTAT_ADDR, 8'h00);
    bus(1'b1, EVMASK_ADDR, 8'h02);
    pulse(1);
    rchk(EVSTAT_ADDR, 8'h02);
    chk(irq, 32'h1);
    bus(1'b1, EVMASK_ADDR, 8'h00);
    rchk(EVMASK_ADDR, 8'h00);
    chk(irq, 32'h0);
    bus(1'b1, EVMASK_ADDR, 8'h02);
    bus(1'b1, EVSTAT_ADDR, 8'h02);
    rchk(EVSTAT_ADDR, 8'h00);
    chk(irq, 32'h0);
  endtask

  // Reset in mid-run: enables drop to zero, pins give no false edge
  task automatic sc_rerun();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk(t0_ctrl, 32'h00);
    rchk(SYSMODE_ADDR, 8'h00);
    rchk(P0FLAGS_ADDR, 8'h00);
    chk(irq_req, 32'h0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    sc_reset();
    sc_gate();
    sc_ack(1'b0);
    sc_ack(1'b1);
    sc_ext();
    sc_evt();
    sc_rerun();
    end_of_test();
  end
endmodule // single_vector_interrupt_control_tb_top

bind single_vector_interrupt_control irq_ctrl_sva i_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .instr_end(instr_end), .interrupt_return_instr_exec(interrupt_return_instr_exec),
  .int_cycle(int_cycle), .irq_req(irq_req), .push_valid(push_valid),
  .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
  .branch_valid(branch_valid), .restore_valid(restore_valid),
  .pop_req(pop_req));

// File: verilog/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // ==========================================================
  // Register map: printed offsets are indices, byte addr = 4x
  localparam logic [9:0]  SYSMODE_IDX   = 10'h0df;
  localparam logic [9:0]  PWMCTL_IDX    = 10'h0e3;
  localparam logic [9:0]  P0FLAGS_IDX   = 10'h0e8;
  localparam logic [9:0]  T0CTL_IDX     = 10'h0f4;
  localparam logic [9:0]  EVSTAT_IDX    = 10'h100;
  localparam logic [9:0]  EVMASK_IDX    = 10'h101;
  localparam logic [11:0] SYSMODE_ADDR  = {SYSMODE_IDX, 2'b00};
  localparam logic [11:0] PWMCTL_ADDR   = {PWMCTL_IDX, 2'b00};
  localparam logic [11:0] P0FLAGS_ADDR  = {P0FLAGS_IDX, 2'b00};
  localparam logic [11:0] T0CTL_ADDR    = {T0CTL_IDX, 2'b00};
  localparam logic [11:0] EVSTAT_ADDR   = {EVSTAT_IDX, 2'b00};
  localparam logic [11:0] EVMASK_ADDR   = {EVMASK_IDX, 2'b00};

  // ==========================================================
  // Field positions
  localparam int GE_BIT        = 2;
  localparam int PAGE_LSB      = 0;
  localparam int SRC_EN_BIT    = 1;
  localparam int SRC_PEND_BIT  = 0;
  localparam int CNT_CLR_BIT   = 3;
  localparam int PWM_CNT_EN    = 2;
  localparam int PWM_RELOAD    = 4;
  localparam int CLK_SEL_LSB   = 6;
  localparam int EXTA_PEND_BIT = 0;
  localparam int EXTA_EN_BIT   = 1;
  localparam int EXTB_PEND_BIT = 2;
  localparam int EXTB_EN_BIT   = 3;

  // Writable bits and reset values
  localparam logic [7:0] SYSMODE_WMASK = 8'h07;
  localparam logic [7:0] PWMCTL_WMASK  = 8'hdf;
  localparam logic [7:0] P0FLAGS_WMASK = 8'h0f;
  localparam logic [7:0] T0CTL_WMASK   = 8'hcb;
  localparam logic [7:0] REG_RESET     = 8'h00;

  // ==========================================================
  // Sources and event status layout
  localparam int NSRC     = 4;
  localparam int NEVT     = 6;
  localparam int EV_PWM   = 0;
  localparam int EV_T0    = 1;
  localparam int EV_EXTA  = 2;
  localparam int EV_EXTB  = 3;
  localparam int EV_ACK   = 4;
  localparam int EV_RET   = 5;

  // Vector locations in program memory
  localparam logic [15:0] VEC_HI_ADDR = 16'h0000;
  localparam logic [15:0] VEC_LO_ADDR = 16'h0001;

  // AHB encodings
  localparam logic [1:0] HRESP_OKAY = 2'b00;

  // ==========================================================
  // Interrupt machine cycle sequencer states
  typedef enum logic [3:0] {
    S_IDLE,
    S_ACK,
    S_PUSH_PCL,
    S_PUSH_PCH,
    S_PUSH_FLAGS,
    S_FETCH_HI,
    S_FETCH_LO,
    S_BRANCH,
    S_POP_FLAGS,
    S_POP_PCH,
    S_POP_PCL,
    S_RESTORE
  } seq_state_t;

endpackage

// File: verilog/pin_fall_detect.sv
// ==========================================================
// Synchronise external pins, flag each falling edge
module pin_fall_detect #(
  parameter int N = 2
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [N-1:0] pin,
  output logic      [N-1:0] fall
);

  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  logic [N-1:0] prev_r;
  logic [N-1:0] sync1_nxt;
  logic [N-1:0] sync2_nxt;
  logic [N-1:0] prev_nxt;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      // First stage is read only by the second stage
      always_comb begin
        sync1_nxt[i] = pin[i];
        sync2_nxt[i] = sync1_r[i];
        prev_nxt[i]  = sync2_r[i];
      end

      // Idle level is high so reset creates no false edge
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_r[i] <= 1'b1;
          sync2_r[i] <= 1'b1;
          prev_r[i]  <= 1'b1;
        end else begin
          sync1_r[i] <= sync1_nxt[i];
          sync2_r[i] <= sync2_nxt[i];
          prev_r[i]  <= prev_nxt[i];
        end
      end

      assign fall[i] = prev_r[i] & ~sync2_r[i];
    end
  endgenerate

endmodule // pin_fall_detect

// File: verilog/single_vector_interrupt_control.sv
// Summary of operation
// - System mode bit 2 is global enable.
// - System mode bits 1..0 select page.
// - Each source sets its own pending flag.
// - Service needs global and source enables set.
// - Acknowledge only at instruction boundary.
// - Machine cycle first clears global enable.
// - Push PC low, PC high, then flags.
// - Fetch vector high 0000, low 0001, branch.
// - Return restores PC, flags, sets global enable.
// - Four sources share one vector.
// - Pending reads 1; write 0 clears.
// - Timer 0 control: enable bit1, pending bit0.
// - Port 0 falling edges, flags register.
// - PWM control: enable bit1, pending bit0.
module single_vector_interrupt_control
  import irq_ctrl_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        pwm_ovf_evt,
  input  wire logic        t0_match_evt,
  input  wire logic        ext_irq_line_a,
  input  wire logic        ext_irq_line_b,
  input  wire logic        instr_end,
  input  wire logic        ei_exec,
  input  wire logic        di_exec,
  input  wire logic        interrupt_return_instr_exec,
  input  wire logic [15:0] pc_cur,
  input  wire logic [7:0]  flags_cur,
  output logic             push_valid,
  output logic      [7:0]  push_data,
  output logic             pop_req,
  input  wire logic        pop_valid,
  input  wire logic [7:0]  pop_data,
  output logic             mem_rd,
  output logic      [15:0] mem_addr,
  input  wire logic        mem_rvalid,
  input  wire logic [7:0]  mem_rdata,
  output logic             branch_valid,
  output logic      [15:0] branch_pc,
  output logic             restore_valid,
  output logic      [15:0] restore_pc,
  output logic      [7:0]  restore_flags,
  output logic             int_cycle,
  output logic             irq_req,
  output logic      [1:0]  page_sel,
  output logic      [7:0]  t0_ctrl,
  output logic      [7:0]  pwm_ctrl,
  output logic             irq
);

  import irq_ctrl_pkg::*;

  // ==========================================================
  // Declarations
  logic [7:0]      sysmode_r, sysmode_nxt;
  logic [7:0]      t0ctl_r, t0ctl_nxt;
  logic [7:0]      pwmctl_r, pwmctl_nxt;
  logic [7:0]      p0flags_r, p0flags_nxt;
  logic [NEVT-1:0] evstat_r, evstat_nxt;
  logic [NEVT-1:0] evmask_r, evmask_nxt;
  logic            dph_wr_r, dph_wr_nxt;
  logic            dph_rd_r, dph_rd_nxt;
  logic [11:0]     dph_addr_r, dph_addr_nxt;
  logic [31:0]     hrdata_r, hrdata_nxt;

  seq_state_t      state_r, state_nxt;
  logic [15:0]     pc_r, pc_nxt;
  logic [7:0]      flags_r, flags_nxt;
  logic [7:0]      vec_hi_r, vec_hi_nxt;
  logic [7:0]      push_data_r, push_data_nxt;
  logic [15:0]     mem_addr_r, mem_addr_nxt;
  logic [15:0]     branch_pc_r, branch_pc_nxt;
  logic [15:0]     rst_pc_r, rst_pc_nxt;
  logic [7:0]      rst_flags_r, rst_flags_nxt;

  logic [1:0]      ext_fall;
  logic [NSRC-1:0] src_pend;
  logic [NSRC-1:0] src_en;
  logic            addr_ok;
  logic            wr_now;
  logic            ack_step;
  logic            ret_step;
  logic [7:0]      wbyte;

  // ==========================================================
  // External pins: synchronised falling edge detection
  pin_fall_detect #(
    .N (2)
  ) u_pin_fall (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     ({ext_irq_line_b, ext_irq_line_a}),
    .fall    (ext_fall)
  );

  // Per-source pending and enable, all on one vector
  assign src_pend = {p0flags_r[EXTB_PEND_BIT], p0flags_r[EXTA_PEND_BIT],
                     t0ctl_r[SRC_PEND_BIT], pwmctl_r[SRC_PEND_BIT]};
  assign src_en   = {p0flags_r[EXTB_EN_BIT], p0flags_r[EXTA_EN_BIT],
                     t0ctl_r[SRC_EN_BIT], pwmctl_r[SRC_EN_BIT]};

  // Request needs both global and source enable
  assign irq_req  = sysmode_r[GE_BIT] & (|(src_pend & src_en));

  assign ack_step = (state_r == S_ACK);
  assign ret_step = (state_r == S_RESTORE);

  // ==========================================================
  // AHB-Lite slave: writes zero wait, reads one wait state
  assign addr_ok = hsel & htrans[1] & hready;
  assign wr_now  = dph_wr_r;
  assign wbyte   = hwdata[7:0];

  // Read mux; unmapped words read zero
  function automatic logic [31:0] read_word(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      SYSMODE_ADDR: v = {24'h00_0000, sysmode_r};
      PWMCTL_ADDR:  v = {24'h00_0000, pwmctl_r};
      P0FLAGS_ADDR: v = {24'h00_0000, p0flags_r};
      T0CTL_ADDR:   v = {24'h00_0000, t0ctl_r};
      EVSTAT_ADDR:  v = {26'h000_0000, evstat_r};
      EVMASK_ADDR:  v = {26'h000_0000, evmask_r};
      default:      v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Bus phases and register next values
  always_comb begin
    dph_wr_nxt   = 1'b0;
    dph_rd_nxt   = 1'b0;
    dph_addr_nxt = dph_addr_r;
    hrdata_nxt   = hrdata_r;
    sysmode_nxt  = sysmode_r;
    t0ctl_nxt    = t0ctl_r;
    pwmctl_nxt   = pwmctl_r;
    p0flags_nxt  = p0flags_r;
    evmask_nxt   = evmask_r;
    evstat_nxt   = evstat_r;

    // A read stalls one cycle so it sees any write just before it
    if (dph_rd_r) begin
      hrdata_nxt = read_word(dph_addr_r);
    end else if (addr_ok) begin
      dph_wr_nxt   = hwrite;
      dph_rd_nxt   = ~hwrite;
      dph_addr_nxt = haddr[11:0];
    end

    // Software writes; pending bits only clear on a written zero
    if (wr_now) begin
      case (dph_addr_r)
        SYSMODE_ADDR: sysmode_nxt = wbyte & SYSMODE_WMASK;
        T0CTL_ADDR: begin
          t0ctl_nxt = (wbyte & T0CTL_WMASK & 8'hfe)
                    | {7'h00, t0ctl_r[SRC_PEND_BIT] & wbyte[SRC_PEND_BIT]};
        end
        PWMCTL_ADDR: begin
          pwmctl_nxt = (wbyte & PWMCTL_WMASK & 8'hfe)
                     | {7'h00, pwmctl_r[SRC_PEND_BIT] & wbyte[SRC_PEND_BIT]};
        end
        P0FLAGS_ADDR: begin
          p0flags_nxt = (wbyte & 8'h0a)
                      | (p0flags_r & wbyte & 8'h05);
        end
        EVSTAT_ADDR: evstat_nxt = evstat_r & ~wbyte[NEVT-1:0];
        EVMASK_ADDR: evmask_nxt = wbyte[NEVT-1:0];
        default: ;
      endcase
    end

    // Hardware sets after software clears: a same-cycle set wins
    pwmctl_nxt[SRC_PEND_BIT]   |= pwm_ovf_evt;
    t0ctl_nxt[SRC_PEND_BIT]    |= t0_match_evt;
    p0flags_nxt[EXTA_PEND_BIT] |= ext_fall[0];
    p0flags_nxt[EXTB_PEND_BIT] |= ext_fall[1];
    evstat_nxt = evstat_nxt | {ret_step, ack_step, ext_fall[1],
                               ext_fall[0], t0_match_evt, pwm_ovf_evt};

    // Return, then machine cycle, then disable, then enable, then bus
    if (ret_step) begin
      sysmode_nxt[GE_BIT] = 1'b1;
    end else if (ack_step) begin
      sysmode_nxt[GE_BIT] = 1'b0;
    end else if (ei_exec || di_exec) begin
      sysmode_nxt[GE_BIT] = ei_exec & ~di_exec;
    end
  end

  // Registers: global enable resets clear, software must set it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysmode_r  <= REG_RESET;
      t0ctl_r    <= REG_RESET;
      pwmctl_r   <= REG_RESET;
      p0flags_r  <= REG_RESET;
      evstat_r   <= '0;
      evmask_r   <= '0;
      dph_wr_r   <= 1'b0;
      dph_rd_r   <= 1'b0;
      dph_addr_r <= 12'h000;
      hrdata_r   <= 32'h0000_0000;
    end else begin
      sysmode_r  <= sysmode_nxt;
      t0ctl_r    <= t0ctl_nxt;
      pwmctl_r   <= pwmctl_nxt;
      p0flags_r  <= p0flags_nxt;
      evstat_r   <= evstat_nxt;
      evmask_r   <= evmask_nxt;
      dph_wr_r   <= dph_wr_nxt;
      dph_rd_r   <= dph_rd_nxt;
      dph_addr_r <= dph_addr_nxt;
      hrdata_r   <= hrdata_nxt;
    end
  end

  assign hreadyout = ~dph_rd_r;
  assign hresp     = HRESP_OKAY[0];
  assign hrdata    = hrdata_r;
  assign irq       = |(evstat_r & evmask_r);
  assign page_sel  = sysmode_r[PAGE_LSB +: 2];
  assign t0_ctrl   = t0ctl_r;
  assign pwm_ctrl  = pwmctl_r;

  // ==========================================================
  // Interrupt machine cycle and return sequencer
  always_comb begin
    state_nxt     = state_r;
    pc_nxt        = pc_r;
    flags_nxt     = flags_r;
    vec_hi_nxt    = vec_hi_r;
    push_data_nxt = push_data_r;
    mem_addr_nxt  = mem_addr_r;
    branch_pc_nxt = branch_pc_r;
    rst_pc_nxt    = rst_pc_r;
    rst_flags_nxt = rst_flags_r;
    case (state_r)
      S_IDLE: begin
        // Return takes precedence: it is the finishing instruction
        if (interrupt_return_instr_exec) begin
          state_nxt = S_POP_FLAGS;
        end else if (instr_end && irq_req) begin
          state_nxt = S_ACK;
          pc_nxt    = pc_cur;
          flags_nxt = flags_cur;
        end
      end
      S_ACK: begin
        state_nxt     = S_PUSH_PCL;
        push_data_nxt = pc_r[7:0];
      end
      S_PUSH_PCL: begin
        state_nxt     = S_PUSH_PCH;
        push_data_nxt = pc_r[15:8];
      end
      S_PUSH_PCH: begin
        state_nxt     = S_PUSH_FLAGS;
        push_data_nxt = flags_r;
      end
      S_PUSH_FLAGS: begin
        state_nxt    = S_FETCH_HI;
        mem_addr_nxt = VEC_HI_ADDR;
      end
      S_FETCH_HI: begin
        if (mem_rvalid) begin
          vec_hi_nxt   = mem_rdata;
          mem_addr_nxt = VEC_LO_ADDR;
          state_nxt    = S_FETCH_LO;
        end
      end
      S_FETCH_LO: begin
        if (mem_rvalid) begin
          branch_pc_nxt = {vec_hi_r, mem_rdata};
          state_nxt     = S_BRANCH;
        end
      end
      S_BRANCH: state_nxt = S_IDLE;
      // Pops come back in reverse push order
      S_POP_FLAGS: begin
        if (pop_valid) begin
          rst_flags_nxt = pop_data;
          state_nxt     = S_POP_PCH;
        end
      end
      S_POP_PCH: begin
        if (pop_valid) begin
          rst_pc_nxt[15:8] = pop_data;
          state_nxt        = S_POP_PCL;
        end
      end
      S_POP_PCL: begin
        if (pop_valid) begin
          rst_pc_nxt[7:0] = pop_data;
          state_nxt       = S_RESTORE;
        end
      end
      S_RESTORE: state_nxt = S_IDLE;
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r     <= S_IDLE;
      pc_r        <= 16'h0000;
      flags_r     <= 8'h00;
      vec_hi_r    <= 8'h00;
      push_data_r <= 8'h00;
      mem_addr_r  <= 16'h0000;
      branch_pc_r <= 16'h0000;
      rst_pc_r    <= 16'h0000;
      rst_flags_r <= 8'h00;
    end else begin
      state_r     <= state_nxt;
      pc_r        <= pc_nxt;
      flags_r     <= flags_nxt;
      vec_hi_r    <= vec_hi_nxt;
      push_data_r <= push_data_nxt;
      mem_addr_r  <= mem_addr_nxt;
      branch_pc_r <= branch_pc_nxt;
      rst_pc_r    <= rst_pc_nxt;
      rst_flags_r <= rst_flags_nxt;
    end
  end

  // Strobes decode from state; data come from flip-flops
  assign push_valid    = (state_r == S_PUSH_PCL) ||
                         (state_r == S_PUSH_PCH) ||
                         (state_r == S_PUSH_FLAGS);
  assign push_data     = push_data_r;
  assign mem_rd        = (state_r == S_FETCH_HI) ||
                         (state_r == S_FETCH_LO);
  assign mem_addr      = mem_addr_r;
  assign pop_req       = (state_r == S_POP_FLAGS) ||
                         (state_r == S_POP_PCH) ||
                         (state_r == S_POP_PCL);
  assign branch_valid  = (state_r == S_BRANCH);
  assign branch_pc     = branch_pc_r;
  assign restore_valid = ret_step;
  assign restore_pc    = rst_pc_r;
  assign restore_flags = rst_flags_r;
  assign int_cycle     = (state_r != S_IDLE);

endmodule // single_vector_interrupt_control
